// *** logic/nvsf_dev.sv ***
// Serial front end of a 64K x 8 nonvolatile SRAM, the slave end.
// Assumes pins arrive unsynchronised; the link clock is oversampled.
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module nvsf_dev
  import nvsf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  nvsf_if.dev link,
  output logic nv_busy,
  output logic link_mode3,
  output logic auto_save_en
);
  typedef enum logic [2:0] {
    ST_CMD = 3'b000,
    ST_ADH = 3'b001,
    ST_ADL = 3'b011,
    ST_DUM = 3'b010,
    ST_XFER = 3'b110,
    ST_STAT = 3'b111,
    ST_SKIP = 3'b101
  } nvsf_st_t;
  typedef struct packed {
    nvsf_st_t st;
    nvsf_kind_t kind;
    logic sel;
    logic mode3;
    logic sck_q;
    logic [2:0] bits;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [MEM_AW-1:0] addr;
    logic so;
    logic wen;
    logic [1:0] bp;
    logic auto_en;
    logic dirty;
    logic busy;
    logic is_store;
    logic [15:0] nv_cnt;
    logic [7:0] hd_cnt;
  } nvsf_dev_t;
  nvsf_dev_t st_ff;
  nvsf_dev_t nxt_st;
  logic [7:0] sram [MEM_WORDS];
  logic [7:0] nvm [MEM_WORDS];
  logic cs_s, sck_s, si_s, hold_s_n, wp_s_n, busy_s;
  logic rise, fall, mem_we, do_store, do_recall, hw_go, nv_free;
  logic [7:0] byte_v;
  logic [7:0] rd_data;
  logic [MEM_AW-1:0] rd_a;
  // ==========================================================
  // Pin synchronisers; idle levels on reset
  nvsf_sync #(.W(6), .RST(6'h3f)) u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .d({link.cs_n, link.sck, link.si, link.hold_n, link.wp_n,
        link.busy_pin}),
    .q({cs_s, sck_s, si_s, hold_s_n, wp_s_n, busy_s})
  );

  // Protected region check of the two protect bits
  function automatic logic prot(input logic [1:0] bp,
                                input logic [MEM_AW-1:0] a);
    unique case (bp)
      2'h0: prot = 1'b0;
      2'h1: prot = (a[MEM_AW-1:MEM_AW-2] == 2'h3);
      2'h2: prot = a[MEM_AW-1];
      2'h3: prot = 1'b1;
    endcase
  endfunction

  // Status byte as the master reads it
  function automatic logic [7:0] status(input nvsf_dev_t s);
    status = 8'h00;
    status[SR_RDY] = s.busy;
    status[SR_WEN] = s.wen;
    status[SR_BP_HI:SR_BP_LO] = s.bp;
    status[SR_AUTO] = s.auto_en;
  endfunction

  // ==========================================================
  // Next state: nonvolatile engine, then the serial sequence
  always_comb begin
    nxt_st = st_ff;
    mem_we = 1'b0;
    do_store = 1'b0;
    do_recall = 1'b0;
    hw_go = 1'b0;
    rd_a = st_ff.addr;
    byte_v = {st_ff.sh[6:0], si_s};
    rise = sck_s & ~st_ff.sck_q;
    fall = ~sck_s & st_ff.sck_q;
    nxt_st.sck_q = sck_s;
    nv_free = ~st_ff.busy & (st_ff.hd_cnt == 8'h00);
    // Countdown of a running store or recall
    if (st_ff.busy) begin
      nxt_st.nv_cnt = st_ff.nv_cnt - 16'h0001;
      if (st_ff.nv_cnt == 16'h0001) begin
        nxt_st.busy = 1'b0;
        // Active high drive only follows a store
        nxt_st.hd_cnt = st_ff.is_store ? 8'(HIGH_DRV_CYC) : 8'h00;
      end
    end else if (st_ff.hd_cnt != 8'h00) begin
      nxt_st.hd_cnt = st_ff.hd_cnt - 8'h01;
    end else if (!busy_s && st_ff.dirty) begin
      hw_go = 1'b1;
    end
    // Serial sequence; standby whenever chip select is high
    if (cs_s) begin
      nxt_st.sel = 1'b0;
      nxt_st.st = ST_CMD;
      nxt_st.bits = 3'h0;
    end else if (!st_ff.sel) begin
      nxt_st.sel = 1'b1;
      nxt_st.mode3 = sck_s;
      nxt_st.st = ST_CMD;
      nxt_st.bits = 3'h0;
    end else if (!hold_s_n) begin
      nxt_st.sck_q = st_ff.sck_q;
    end else if (rise) begin
      nxt_st.sh = byte_v;
      nxt_st.bits = st_ff.bits + 3'h1;
      if (st_ff.bits == 3'h7) begin
        unique case (st_ff.st)
          ST_CMD: begin
            nxt_st.st = ST_SKIP;
            unique case (byte_v)
              OP_WREN: nxt_st.wen = 1'b1;
              OP_WRITE_DISABLE_INSTRUCTION: nxt_st.wen = 1'b0;
              OP_RDSR: begin
                nxt_st.st = ST_STAT;
                nxt_st.tx = status(st_ff);
              end
              OP_WRSR: begin
                nxt_st.kind = K_STATUS;
                nxt_st.st = ST_XFER;
              end
              OP_READ: begin
                nxt_st.kind = K_READ;
                nxt_st.st = ST_ADH;
              end
              OP_FAST_READ: begin
                nxt_st.kind = K_FAST;
                nxt_st.st = ST_ADH;
              end
              OP_WRITE: begin
                nxt_st.kind = K_WRITE;
                nxt_st.st = ST_ADH;
              end
              OP_STORE: begin
                do_store = nv_free & ~hw_go;
              end
              OP_RECALL: begin
                do_recall = nv_free & ~hw_go;
              end
              OP_AUTO_SAVE_EN: nxt_st.auto_en = 1'b1;
              OP_AUTO_SAVE_DIS: nxt_st.auto_en = 1'b0;
              default: nxt_st.st = ST_SKIP;
            endcase
          end
          ST_ADH: begin
            nxt_st.addr = {byte_v, st_ff.addr[7:0]};
            nxt_st.st = ST_ADL;
          end
          ST_ADL: begin
            nxt_st.addr = {st_ff.addr[MEM_AW-1:8], byte_v};
            rd_a = {st_ff.addr[MEM_AW-1:8], byte_v};
            nxt_st.st = (st_ff.kind == K_FAST) ? ST_DUM : ST_XFER;
            nxt_st.tx = rd_data;
          end
          ST_DUM: begin
            nxt_st.st = ST_XFER;
            nxt_st.tx = rd_data;
          end
          ST_XFER: begin
            if (st_ff.kind == K_STATUS) begin
              // Protect bits change only with the pin released
              if (st_ff.wen && wp_s_n) begin
                nxt_st.bp = byte_v[SR_BP_HI:SR_BP_LO];
              end
              nxt_st.st = ST_SKIP;
            end else begin
              // Burst address wraps past the top to zero
              nxt_st.addr = st_ff.addr + 16'h0001;
              rd_a = st_ff.addr + 16'h0001;
              nxt_st.tx = rd_data;
              if (st_ff.kind == K_WRITE) begin
                mem_we = st_ff.wen & wp_s_n & ~st_ff.busy &
                         ~prot(st_ff.bp, st_ff.addr);
                nxt_st.dirty = st_ff.dirty | mem_we;
              end
            end
          end
          ST_STAT: nxt_st.tx = status(st_ff);
          ST_SKIP: nxt_st.st = ST_SKIP;
          default: nxt_st.st = ST_SKIP;
        endcase
      end
    end else if (fall && (st_ff.st == ST_XFER || st_ff.st == ST_STAT)) begin
      nxt_st.so = st_ff.tx[7];
      nxt_st.tx = {st_ff.tx[6:0], 1'b0};
    end
    // Starting an operation: busy count and dirty flag
    if (hw_go || do_store || do_recall) begin
      nxt_st.busy = 1'b1;
      nxt_st.is_store = ~do_recall;
      nxt_st.nv_cnt = do_recall ? 16'(RECALL_CYC) : 16'(STORE_CYC);
      nxt_st.dirty = mem_we; // A write in the start cycle stays unsaved
    end
  end

  // Refused reads return zero while an operation runs
  assign rd_data = st_ff.busy ? 8'h00 : sram[rd_a];

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '{st: ST_CMD, kind: K_READ, sck_q: 1'b1, bp: BP_RST,
                 auto_en: AUTO_RST, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Array and its shadow; a store copies every word in one edge
  always_ff @(posedge ref_clk) begin
    if (do_recall) begin
      sram <= nvm;
    end else if (mem_we) begin
      sram[st_ff.addr] <= byte_v;
    end
    if (hw_go || do_store) begin
      nvm <= sram;
    end
  end

  // ==========================================================
  // Pins: busy line is open drain with a short high drive
  assign link.so = st_ff.so;
  assign link.so_oe = st_ff.sel & hold_s_n;
  assign link.busy_dev_o = ~st_ff.busy;
  assign link.busy_dev_oe = st_ff.busy | (st_ff.hd_cnt != 8'h00);
  assign nv_busy = st_ff.busy;
  assign link_mode3 = st_ff.mode3;
  assign auto_save_en = st_ff.auto_en;
endmodule
`default_nettype wire

// *** logic/nvsf_pkg.sv ***
// Constants shared by the nvSRAM serial front end and its controller.
// Assumes both ends run on one 20 MHz ref_clk.
package nvsf_pkg;
  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned T_STORE_NS = 8000;
  localparam int unsigned T_RECALL_NS = 4000;
  localparam int unsigned BUSY_PIN_HIGH_DRIVE_TIME_NS = 500;
  localparam int unsigned STORE_CYC = (T_STORE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RECALL_CYC = (T_RECALL_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HIGH_DRV_CYC =
    (BUSY_PIN_HIGH_DRIVE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SCK_HALF_CYC = 8;
  // ==========================================================
  // Array
  localparam int unsigned MEM_AW = 16;
  localparam int unsigned MEM_WORDS = 65536;
  // ==========================================================
  // Instruction codes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE_INSTRUCTION = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_STORE = 8'h3c;
  localparam logic [7:0] OP_RECALL = 8'h60;
  localparam logic [7:0] OP_AUTO_SAVE_EN = 8'h59;
  localparam logic [7:0] OP_AUTO_SAVE_DIS = 8'h19;
  // ==========================================================
  // Status byte layout and reset values
  localparam int unsigned SR_RDY = 0;
  localparam int unsigned SR_WEN = 1;
  localparam int unsigned SR_BP_LO = 2;
  localparam int unsigned SR_BP_HI = 3;
  localparam int unsigned SR_AUTO = 6;
  localparam logic [1:0] BP_RST = 2'h0;
  localparam logic AUTO_RST = 1'b1;
  // ==========================================================
  // Controller registers (byte offsets) and control bits
  localparam logic [7:0] RG_CTRL = 8'h00;
  localparam logic [7:0] RG_TX = 8'h04;
  localparam logic [7:0] RG_RX = 8'h08;
  localparam logic [7:0] RG_STAT = 8'h0c;
  localparam int unsigned CT_START = 0;
  localparam int unsigned CT_SEL = 1;
  localparam int unsigned CT_MODE3 = 2;
  localparam int unsigned CT_SUSPEND = 3;
  localparam int unsigned CT_WPROT = 4;
  localparam int unsigned CT_HWSTORE = 5;
  localparam logic [5:0] CTRL_RST = 6'h00;
  // ==========================================================
  // Kinds of serial access
  typedef enum logic [1:0] {
    K_READ = 2'h0,
    K_FAST = 2'h1,
    K_WRITE = 2'h2,
    K_STATUS = 2'h3
  } nvsf_kind_t;
endpackage

// *** logic/nvsf_if.sv ***
// Pin bundle between the serial nvSRAM front end and its controller.
// Resolves the open-drain busy line and the released serial output.
`timescale 1ns/1ps
`default_nettype none
interface nvsf_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic wp_n;
  logic hold_n;
  logic busy_dev_o;
  logic busy_dev_oe;
  logic busy_host_o;
  logic busy_host_oe;
  logic so_line;
  logic busy_pin;
  // ==========================================================
  // Wire resolution; weak pull-up wins only when nobody drives
  assign so_line = so_oe ? so : 1'b1;
  assign busy_pin = ((busy_dev_oe & ~busy_dev_o) |
                     (busy_host_oe & ~busy_host_o)) ? 1'b0 : 1'b1;
  modport dev (input cs_n, input sck, input si, input wp_n,
    input hold_n, input busy_pin, output so, output so_oe,
    output busy_dev_o, output busy_dev_oe);
  modport host (output cs_n, output sck, output si, output wp_n,
    output hold_n, output busy_host_o, output busy_host_oe,
    input so_line, input busy_pin);
endinterface
`default_nettype wire

// *** logic/nvsf_sync.sv ***
// Two-stage synchroniser for pins entering the ref_clk domain.
// Assumes inputs are levels; edges are found after the second stage.
`timescale 1ns/1ps
`default_nettype none
module nvsf_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } nvsf_sync_t;
  nvsf_sync_t st_ff;
  nvsf_sync_t nxt_st;
  // ==========================================================
  // First stage feeds only the second
  always_comb begin
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= {RST, RST};
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign q = st_ff.s2;
endmodule
`default_nettype wire

// *** logic/nvsf_host.sv ***
// Controller end: byte-wide SPI master driven by AHB-Lite registers.
// Assumes software sequences opcode, address and data bytes itself.
`timescale 1ns/1ps
`default_nettype none
module nvsf_host
  import nvsf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  nvsf_if.host link,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_LOW = 2'b01,
    H_HIGH = 2'b11
  } nvsf_hst_t;
  typedef struct packed {
    nvsf_hst_t hst;
    logic [5:0] ctrl;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] sh;
    logic [2:0] bits;
    logic [3:0] cnt;
    logic sck;
    logic mosi;
    logic wpend;
    logic [7:0] waddr;
    logic [31:0] hrdata;
  } nvsf_host_t;
  nvsf_host_t st_ff;
  nvsf_host_t nxt_st;
  logic so_s, busy_s, go, half_end;
  // ==========================================================
  // Far-end pins synchronised before use
  nvsf_sync #(.W(2), .RST(2'h3)) u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .d({link.so_line, link.busy_pin}),
    .q({so_s, busy_s})
  );

  // ==========================================================
  // Bus slave, register file and bit engine
  always_comb begin
    nxt_st = st_ff;
    go = 1'b0;
    half_end = (st_ff.cnt == 4'(SCK_HALF_CYC - 1));
    nxt_st.ctrl[CT_START] = 1'b0;
    // Data phase of a write; only whole words are taken
    if (st_ff.wpend) begin
      nxt_st.wpend = 1'b0;
      unique case (st_ff.waddr)
        RG_CTRL: begin
          nxt_st.ctrl = hwdata[5:0];
          go = hwdata[CT_START] & (st_ff.hst == H_IDLE);
        end
        RG_TX: nxt_st.tx = hwdata[7:0];
        default: nxt_st.wpend = 1'b0;
      endcase
    end
    // Address phase; read data registered for zero wait
    if (hsel && htrans[1] && hready) begin
      nxt_st.wpend = hwrite & (hsize == 3'h2);
      nxt_st.waddr = haddr[7:0];
      unique case (haddr[7:0])
        RG_CTRL: nxt_st.hrdata = {26'h0, st_ff.ctrl};
        RG_TX: nxt_st.hrdata = {24'h0, st_ff.tx};
        RG_RX: nxt_st.hrdata = {24'h0, st_ff.rx};
        RG_STAT: nxt_st.hrdata = {30'h0, ~busy_s, st_ff.hst != H_IDLE};
        default: nxt_st.hrdata = 32'h0;
      endcase
    end
    // One bit: low half then high half; suspend freezes the count
    unique case (st_ff.hst)
      H_IDLE: begin
        if (go) begin
          nxt_st.hst = H_LOW;
          nxt_st.sh = st_ff.tx;
          nxt_st.mosi = st_ff.tx[7];
          nxt_st.bits = 3'h0;
          nxt_st.cnt = 4'h0;
        end
      end
      H_LOW: begin
        if (!st_ff.ctrl[CT_SUSPEND]) begin
          nxt_st.cnt = st_ff.cnt + 4'h1;
          if (half_end) begin
            nxt_st.hst = H_HIGH;
            nxt_st.cnt = 4'h0;
            nxt_st.sh = {st_ff.sh[6:0], so_s};
          end
        end
      end
      H_HIGH: begin
        if (!st_ff.ctrl[CT_SUSPEND]) begin
          nxt_st.cnt = st_ff.cnt + 4'h1;
          if (half_end) begin
            nxt_st.cnt = 4'h0;
            nxt_st.bits = st_ff.bits + 3'h1;
            nxt_st.hst = (st_ff.bits == 3'h7) ? H_IDLE : H_LOW;
            // Data line holds after the last bit: in mode 3 sck stays high
            if (st_ff.bits != 3'h7) begin
              nxt_st.mosi = st_ff.sh[7];
            end
            if (st_ff.bits == 3'h7) begin
              nxt_st.rx = st_ff.sh;
            end
          end
        end
      end
      default: nxt_st.hst = H_IDLE;
    endcase
    // Idle level of the clock picks mode 0 or mode 3
    unique case (nxt_st.hst)
      H_LOW: nxt_st.sck = 1'b0;
      H_HIGH: nxt_st.sck = 1'b1;
      default: nxt_st.sck = nxt_st.ctrl[CT_MODE3];
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '{hst: H_IDLE, ctrl: CTRL_RST, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Pins; clock rate far below the normal-read limit
  assign link.cs_n = ~st_ff.ctrl[CT_SEL];
  assign link.sck = st_ff.sck;
  assign link.si = st_ff.mosi;
  assign link.hold_n = ~st_ff.ctrl[CT_SUSPEND];
  assign link.wp_n = ~st_ff.ctrl[CT_WPROT];
  assign link.busy_host_o = 1'b0;
  assign link.busy_host_oe = st_ff.ctrl[CT_HWSTORE];
  assign hrdata = st_ff.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule
`default_nettype wire

// *** tb/nvsf_properties.sv ***
// Checker on the link pins between the nvSRAM controller and device.
// Assumes every pin is sampled on ref_clk; reset is arst_n low.
`timescale 1ns/1ps
`default_nettype none
module nvsf_properties (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic hold_n,
  input wire logic busy_dev_o,
  input wire logic busy_dev_oe
);
  // ==========================================================
  // Helper logic
  logic drv_lo;
  logic drv_hi;
  logic [7:0] lo_cnt_ff;
  logic [7:0] nxt_lo_cnt;
  // Busy drive states; 8 bits cover the longest store
  assign drv_lo = busy_dev_oe & ~busy_dev_o;
  assign drv_hi = busy_dev_oe & busy_dev_o;
  assign nxt_lo_cnt = drv_lo ? lo_cnt_ff + 8'h01 : 8'h00;
  // Length of the current low drive
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      lo_cnt_ff <= 8'h00;
    else
      lo_cnt_ff <= nxt_lo_cnt;
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_lo_end;
    drv_lo ##1 drv_hi;
  endsequence
  sequence s_hi_run;
    drv_hi [*8];
  endsequence
  property p_so_off;
    $rose(cs_n) |-> ##[0:4] !so_oe;
  endproperty
  a_so_off: assert property (p_so_off) else $error("so kept");
  property p_si_low;
    !cs_n && $changed(si) |-> !sck;
  endproperty
  a_si_low: assert property (p_si_low) else $error("si moved");
  property p_so_fall;
    so_oe && $past(so_oe) && $changed(so) |-> !sck;
  endproperty
  a_so_fall: assert property (p_so_fall) else $error("so moved");
  // Host pacing keeps each low half whole
  property p_sck_low;
    !cs_n && $fell(sck) |-> !sck [*8];
  endproperty
  a_sck_low: assert property (p_sck_low) else $error("short");
  property p_sck_hold;
    !hold_n && !$past(hold_n) |-> $stable(sck);
  endproperty
  a_sck_hold: assert property (p_sck_hold) else $error("sck");
  property p_lo_len;
    $fell(drv_lo) |-> lo_cnt_ff inside {[8'd79:8'd81], [8'd159:8'd161]};
  endproperty
  a_lo_len: assert property (p_lo_len) else $error("busy len");
  property p_hi_drive;
    s_lo_end |=> s_hi_run ##[1:2] !busy_dev_oe;
  endproperty
  a_hi_drive: assert property (p_hi_drive) else $error("hi");
  property p_hi_cause;
    $rose(drv_hi) |-> $past(drv_lo);
  endproperty
  a_hi_cause: assert property (p_hi_cause) else $error("hi");
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Bench for the nvSRAM serial front end: controller and device joined.
// Assumes one 20 MHz ref_clk and the link interface between the ends.
`timescale 1ns/1ps
`default_nettype none
module tb
  import nvsf_pkg::*;
;
  // ==========================================================
  // Signals and bookkeeping
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic nv_busy;
  logic link_mode3;
  logic auto_save_en;
  logic [31:0] ctl = 32'h0;
  logic sus = 1'b0;
  logic [7:0] sh [0:65535];
  logic [15:0] at [0:2];
  int failures = 0;
  int checks_done = 0;
  // 50 ns clock
  always #25 ref_clk = ~ref_clk;
  // ==========================================================
  // Both ends and the checker
  nvsf_if link ();
  nvsf_dev nvsf_dev_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .link(link.dev), .nv_busy(nv_busy), .link_mode3(link_mode3),
    .auto_save_en(auto_save_en));
  nvsf_host nvsf_host_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .link(link.host), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp());
  nvsf_properties prop_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .cs_n(link.cs_n), .sck(link.sck), .si(link.si), .so(link.so),
    .so_oe(link.so_oe), .hold_n(link.hold_n),
    .busy_dev_o(link.busy_dev_o), .busy_dev_oe(link.busy_dev_oe));
  // ==========================================================
  // Tasks and expectations
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One AHB single transfer; entered just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // Select change; the gap lets the device see a deselect
  task automatic sel(input logic on);
    logic [31:0] r;
    ctl[CT_SEL] = on;
    ahb(1'b1, RG_CTRL, ctl, r);
    repeat (4) @(posedge ref_clk);
  endtask
  // One byte each way, optionally suspended in mid-byte
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    logic [31:0] r;
    ahb(1'b1, RG_TX, {24'h0, tx}, r);
    ahb(1'b1, RG_CTRL, ctl | 32'h1, r);
    if (sus) begin
      ahb(1'b1, RG_CTRL, ctl | 32'h8, r);
      repeat (30) @(posedge ref_clk);
      ahb(1'b1, RG_CTRL, ctl, r);
    end
    do ahb(1'b0, RG_STAT, 32'h0, r); while (r[0] !== 1'b0);
    ahb(1'b0, RG_RX, 32'h0, r);
    rx = r[7:0];
  endtask
  task automatic op1(input logic [7:0] op, input logic two,
                     input logic [7:0] d, output logic [7:0] r);
    sel(1'b1);
    xfer(op, r);
    if (two)
      xfer(d, r);
    sel(1'b0);
  endtask
  task automatic mem(input logic [7:0] op, input logic [15:0] a,
                     input logic [7:0] d0, input logic [7:0] d1,
                     output logic [7:0] r0, output logic [7:0] r1);
    logic [7:0] x;
    sel(1'b1);
    xfer(op, x);
    xfer(a[15:8], x);
    xfer(a[7:0], x);
    if (op == OP_FAST_READ)
      xfer(8'h00, x);
    xfer(d0, r0);
    xfer(d1, r1);
    sel(1'b0);
  endtask
  task automatic idle();
    do @(posedge ref_clk);
    while (nv_busy !== 1'b0 || link.busy_dev_oe !== 1'b0);
  endtask
  function automatic logic blocked(input logic [1:0] bp,
                                   input logic [15:0] a);
    case (bp)
      2'h1: return a[15:14] == 2'h3;
      2'h2: return a[15];
      2'h3: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] r0, r1, d0, v;
    logic [31:0] w;
    logic s;
    w = $urandom(39);
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    chk("auto_rst", 8'h1, {7'h0, auto_save_en});
    for (int m = 0; m < 2; m++) begin
      ctl[CT_MODE3] = m[0];
      sus = m[0];
      sel(1'b0);
      op1(OP_WREN, 1'b0, 8'h00, r0);
      chk("mode", {7'h0, m[0]}, {7'h0, link_mode3});
      d0 = 8'($urandom);
      v = 8'($urandom);
      mem(OP_WRITE, 16'hffff, d0, v, r0, r1);
      sh[16'hffff] = d0;
      sh[16'h0000] = v;
      mem(OP_READ, 16'hffff, 8'h00, 8'h00, r0, r1);
      chk("rd_top", sh[16'hffff], r0);
      chk("rd_wrap", sh[16'h0000], r1);
      mem(OP_FAST_READ, 16'hffff, 8'h00, 8'h00, r0, r1);
      chk("fast", sh[16'h0000], r1);
      $display("test mode %0d done", m);
    end
    sus = 1'b0;
    for (int i = 0; i < 3; i++)
      at[i] = {2'(i + 1), 14'($urandom)};
    for (int bp = 0; bp < 5; bp++) begin
      op1(OP_WRSR, 1'b1, {4'h0, 2'(bp), 2'h0}, r0);
      op1(OP_RDSR, 1'b1, 8'h00, r0);
      chk("bp", {6'h0, 2'(bp)}, {6'h0, r0[SR_BP_HI:SR_BP_LO]});
      chk("sr", 8'h2, {6'h0, r0[SR_WEN], r0[SR_RDY]});
      for (int i = 0; i < 3 && bp < 4; i++) begin
        d0 = 8'($urandom);
        mem(OP_WRITE, at[i], d0, d0, r0, r1);
        if (!blocked(2'(bp), at[i]))
          sh[at[i]] = d0;
        mem(OP_READ, at[i], 8'h00, 8'h00, r0, r1);
        chk("prot", sh[at[i]], r0);
      end
    end
    $display("test protect done");
    for (int k = 0; k < 2; k++) begin
      if (k == 0)
        op1(OP_WRITE_DISABLE_INSTRUCTION, 1'b0, 8'h00, r0);
      ctl[CT_WPROT] = k[0];
      mem(OP_WRITE, at[0], ~sh[at[0]], 8'h00, r0, r1);
      mem(OP_READ, at[0], 8'h00, 8'h00, r0, r1);
      chk("guard", sh[at[0]], r0);
      op1(OP_WREN, 1'b0, 8'h00, r0);
    end
    ctl[CT_WPROT] = 1'b0;
    // Second store has no write before it
    for (int k = 0; k < 2; k++) begin
      op1(OP_STORE, 1'b0, 8'h00, r0);
      chk("st_busy", 8'h1, {7'h0, nv_busy});
      chk("st_pin", 8'h0, {7'h0, link.busy_pin});
      ahb(1'b0, RG_STAT, 32'h0, w);
      chk("st_seen", 8'h1, {7'h0, w[1]});
      idle();
    end
    // Pin store: ignored when clean, taken after a write
    for (int k = 0; k < 2; k++) begin
      d0 = 8'($urandom);
      if (k == 1)
        mem(OP_WRITE, at[1], d0, d0, r0, r1);
      if (k == 1)
        sh[at[1]] = d0;
      ctl[CT_HWSTORE] = 1'b1;
      ahb(1'b1, RG_CTRL, ctl, w);
      s = 1'b0;
      repeat (12) begin
        @(posedge ref_clk);
        s = s | nv_busy;
      end
      ctl[CT_HWSTORE] = 1'b0;
      ahb(1'b1, RG_CTRL, ctl, w);
      chk("hw_store", {7'h0, k[0]}, {7'h0, s});
      idle();
    end
    v = sh[at[1]];
    mem(OP_WRITE, at[1], ~v, ~v, r0, r1);
    op1(OP_RECALL, 1'b0, 8'h00, r0);
    idle();
    mem(OP_READ, at[1], 8'h00, 8'h00, r0, r1);
    chk("recall", v, r0);
    op1(OP_AUTO_SAVE_DIS, 1'b0, 8'h00, r0);
    chk("auto_off", 8'h0, {7'h0, auto_save_en});
    op1(OP_AUTO_SAVE_EN, 1'b0, 8'h00, r0);
    chk("auto_on", 8'h1, {7'h0, auto_save_en});
    $display("test nonvolatile done");
    end_of_test();
  end
  // Hang guard; the sequence needs roughly 32k cycles
  initial begin
    repeat (90000) @(posedge ref_clk);
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
